/* File: sim/bws_cfg_host.sv */
// Configuration software model: Avalon-MM master with wait handling
`timescale 1ns/1ps
`default_nettype none

module bws_cfg_host (
  input wire logic clock_i,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i,
  output logic [7:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  output logic hang_o
);
  initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'h0;
    hang_o = 1'b0;
  end

  // Holds the request until waitrequest is sampled low, then lets go.
  // No cycle limit here: only the bench timeout ends a wait that never ends.
  // hang_o stays high while a request is outstanding.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge clock_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    hang_o <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_i);
    q = avs_readdata_i;
    hang_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
    // Released lines must not keep showing the last value
    avs_address_o <= ~a;
    avs_writedata_o <= ~d;
    avs_byteenable_o <= ~be;
  endtask
endmodule

`default_nettype wire

/* File: sim/test_bws_window_status.sv */
// Self-checking bench for the bridge window and secondary status bank
`timescale 1ns/1ps
`default_nettype none

module test_bws_window_status;
  import bws_pkg::*;
  logic clock_i;
  logic nrst_i;
  logic ce_i;
  logic [5:0] ev;
  logic [31:0] io_addr;
  logic [31:0] mem_addr;
  logic [7:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_s;
  logic io_fwd;
  logic mem_fwd;
  logic irq;
  logic hang;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  bws_window_status i_bws_window_status (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
    .par_err_i(ev[0]), .cpl_abort_sent_i(ev[1]), .cpl_abort_rcvd_i(ev[2]),
    .cpl_ur_rcvd_i(ev[3]), .err_msg_sent_i(ev[4]), .poisoned_rcvd_i(ev[5]),
    .io_addr_i(io_addr), .mem_addr_i(mem_addr), .io_fwd_o(io_fwd), .mem_fwd_o(mem_fwd),
    .irq_o(irq));

  bws_cfg_host i_bws_cfg_host (.clock_i(clock_i), .avs_readdata_i(rdata),
    .avs_waitrequest_i(wait_s), .avs_address_o(addr), .avs_read_o(rd_s),
    .avs_write_o(wr_s), .avs_writedata_o(wdata), .avs_byteenable_o(be), .hang_o(hang));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    ev = 6'h0;
    io_addr = 32'h0;
    mem_addr = 32'h0;
  end

  task automatic end_of_test;
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Far more than the scenarios need; a stuck handshake ends here
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rst;
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    logic [31:0] q;
    i_bws_cfg_host.xfer(1'b1, a, d, m, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_bws_cfg_host.xfer(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clock_i);
    ev <= m;
    @(posedge clock_i);
    ev <= 6'h0;
  endtask

  task automatic irqchk(input logic exp);
    @(posedge clock_i);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic t_reset_values;
    rdchk(OFF_BUS_LAT, 32'h0);
    rdchk(OFF_IO_STS, 32'h0000_0101);
    rdchk(OFF_MEM, 32'h0);
    rdchk(OFF_IO_UP, 32'h0);
    rdchk(OFF_IRQ_STS, 32'h0);
    irqchk(1'b0);
  endtask

  task automatic t_ro_fields;
    wr(OFF_BUS_LAT, 32'hffff_ffff, 4'hf);
    rdchk(OFF_BUS_LAT, 32'h0);
    wr(OFF_IO_STS, 32'hffff_ffff, 4'hf);
    rdchk(OFF_IO_STS, 32'h0000_f1f1);
    wr(OFF_MEM, 32'hffff_ffff, 4'hf);
    rdchk(OFF_MEM, 32'hfff0_fff0);
    wr(OFF_IO_UP, 32'hffff_ffff, 4'h1);
    rdchk(OFF_IO_UP, 32'h0000_00ff);
    wr(8'h04, 32'hffff_ffff, 4'hf);
    rdchk(8'h04, 32'h0);
  endtask

  task automatic t_windows;
    logic [31:0] ia[5] = '{32'h0001_1fff, 32'h0001_2000, 32'h0001_3fff, 32'h0001_4000,
                           32'h0000_2000};
    logic [31:0] ma[5] = '{32'h001f_ffff, 32'h0020_0000, 32'h003f_ffff, 32'h0040_0000,
                           32'h0030_0000};
    logic [1:0] ex[5] = '{2'b00, 2'b11, 2'b11, 2'b00, 2'b01};
    wr(OFF_IO_UP, 32'h0001_0001, 4'hf);
    wr(OFF_IO_STS, 32'h0000_3020, 4'h3);
    wr(OFF_MEM, 32'h0030_0020, 4'hf);
    rdchk(OFF_IO_STS, 32'h0000_3121);
    rdchk(OFF_IO_UP, 32'h0001_0001);
    foreach (ia[k]) begin
      @(posedge clock_i);
      io_addr <= ia[k];
      mem_addr <= ma[k];
      repeat (2) @(posedge clock_i);
      chk({30'h0, io_fwd, mem_fwd}, {30'h0, ex[k]});
    end
  endtask

  task automatic t_status;
    pulse(6'h3f);
    rdchk(OFF_IO_STS, 32'hb800_0101);
    wr(OFF_CTRL, 32'h3, 4'hf);
    pulse(6'h3f);
    rdchk(OFF_IO_STS, 32'hf900_0101);
    wr(OFF_IO_STS, 32'h0000_0000, 4'hc);
    rdchk(OFF_IO_STS, 32'hf900_0101);
    wr(OFF_IO_STS, 32'hff00_0000, 4'h8);
    rdchk(OFF_IO_STS, 32'h3800_0101);
  endtask

  task automatic t_irq;
    wr(OFF_CTRL, 32'h3, 4'hf);
    pulse(6'h3f);
    rdchk(OFF_IRQ_STS, 32'h0000_003f);
    irqchk(1'b0);
    wr(OFF_IRQ_MASK, 32'h1, 4'hf);
    irqchk(1'b1);
    wr(OFF_IRQ_STS, 32'h1, 4'hf);
    irqchk(1'b0);
    rdchk(OFF_IRQ_STS, 32'h0000_003e);
    pulse(6'h01);
    irqchk(1'b1);
  endtask

  // Clock enable low: events are dropped and the bus waits until it rises
  task automatic t_freeze;
    @(posedge clock_i);
    ce_i <= 1'b0;
    pulse(6'h20);
    fork
      wr(OFF_IRQ_MASK, 32'h0000_003f, 4'hf);
      begin
        repeat (4) @(posedge clock_i);
        chk({31'h0, wait_s}, 32'h1);
        ce_i <= 1'b1;
      end
    join
    rdchk(OFF_IRQ_STS, 32'h0);
    rdchk(OFF_IO_STS, 32'h0000_0101);
    rdchk(OFF_IRQ_MASK, 32'h0000_003f);
    irqchk(1'b0);
  endtask

  initial begin
    rst;
    t_reset_values;
    t_ro_fields;
    rst;
    t_windows;
    rst;
    t_status;
    rst;
    t_irq;
    rst;
    t_freeze;
    chk({31'h0, hang}, 32'h0);
    end_of_test;
  end
endmodule

`default_nettype wire

/* File: src/bws_pkg.sv */
// Package for the bridge window and secondary status register bank
package bws_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_BUS_LAT = 8'h18;
  localparam logic [7:0] OFF_IO_STS = 8'h1c;
  localparam logic [7:0] OFF_MEM = 8'h20;
  localparam logic [7:0] OFF_IO_UP = 8'h30;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam logic [7:0] OFF_IRQ_STS = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h48;

  // Field positions inside the 32-bit words
  localparam int unsigned LAT_LSB = 24;
  localparam int unsigned IO_BASE_IND_LSB = 0;
  localparam int unsigned IO_BASE_LSB = 4;
  localparam int unsigned IO_LIM_IND_LSB = 8;
  localparam int unsigned IO_LIM_LSB = 12;
  localparam int unsigned MEM_BASE_LSB = 4;
  localparam int unsigned MEM_LIM_LSB = 20;
  localparam int unsigned IO_UP_BASE_LSB = 0;
  localparam int unsigned IO_UP_LIM_LSB = 16;
  localparam int unsigned CTRL_PERR_BIT = 0;
  localparam int unsigned CTRL_SERR_BIT = 1;

  // Secondary status bit positions in the 0x1c word
  localparam int unsigned P_MDPE = 24;
  localparam int unsigned P_STA = 27;
  localparam int unsigned P_RTA = 28;
  localparam int unsigned P_RMA = 29;
  localparam int unsigned P_SSE = 30;
  localparam int unsigned P_DPE = 31;

  // Index of each event in the event and status vectors
  localparam int unsigned EV_N = 6;
  localparam int unsigned EV_MDPE = 0;
  localparam int unsigned EV_STA = 1;
  localparam int unsigned EV_RTA = 2;
  localparam int unsigned EV_RMA = 3;
  localparam int unsigned EV_SSE = 4;
  localparam int unsigned EV_DPE = 5;
  localparam logic [EV_N-1:0] SEC_W1C_MASK = 6'h31;

  // Constant field values
  localparam logic [7:0] LAT_VAL = 8'h00;
  localparam logic [3:0] IND_IO32 = 4'h1;
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;
  localparam logic [19:0] MEM_LOW_ZERO = 20'h00000;
  localparam logic [19:0] MEM_LOW_ONES = 20'hfffff;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef logic [EV_N-1:0] bws_evt_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bws_bus_e;

  typedef struct packed {
    bws_bus_e bst;
    logic [31:0] rdata;
    logic [3:0] io_base;
    logic [3:0] io_lim;
    logic [15:0] io_base_up;
    logic [15:0] io_lim_up;
    logic [11:0] mem_base;
    logic [11:0] mem_lim;
    bws_evt_t sec;
    logic perr_en;
    logic serr_en;
    bws_evt_t irq_sts;
    bws_evt_t irq_mask;
    logic io_fwd;
    logic mem_fwd;
  } bws_state_s;

  localparam bws_state_s BWS_RST = '0;

endpackage

/* File: src/bws_window_status.sv */
// Bridge I/O and memory windows, secondary status, Avalon-MM register slave
// Overview of operation
// - Secondary latency timer byte reads zero, read-only
// - I/O base and limit low nibbles read 1h
// - I/O base nibble holds bottom bits 15:12
// - I/O limit nibble holds top bits 15:12
// - Forward I/O inside decoded base to limit window
// - I/O window bits 31:16 from upper registers
// - Legacy status bits zero, reserved bits read zero
// - Bit 24 sets on parity error when enabled
// - Bit 27 sets on sent completer abort
// - Bit 28 sets on received completer abort
// - Bit 29 sets on received unsupported request
// - Bit 30 sets on error message with SERR
// - Bit 31 sets on received poisoned TLP
// - Memory base bits 15:4 hold address 31:20
// - Memory limit holds top; forward inside window
// - Upper I/O base is writable, resets zero
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module bws_window_status
  import bws_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic par_err_i,
  input wire logic cpl_abort_sent_i,
  input wire logic cpl_abort_rcvd_i,
  input wire logic cpl_ur_rcvd_i,
  input wire logic err_msg_sent_i,
  input wire logic poisoned_rcvd_i,
  input wire logic [31:0] io_addr_i,
  input wire logic [31:0] mem_addr_i,
  output logic io_fwd_o,
  output logic mem_fwd_o,
  output logic irq_o
);

  bws_state_s q_ff;
  bws_state_s nxt_q;
  bws_evt_t evt;
  logic [31:0] io_bot;
  logic [31:0] io_top;
  logic [31:0] mem_bot;
  logic [31:0] mem_top;

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_reg = (a == ADDR_W'(off));
  endfunction

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    be_mask = m;
  endfunction

  // Places the event flags at their secondary status positions
  function automatic logic [31:0] sec_word(input bws_evt_t s);
    logic [31:0] w;
    w = '0;
    w[P_MDPE] = s[EV_MDPE];
    w[P_STA] = s[EV_STA];
    w[P_RTA] = s[EV_RTA];
    w[P_RMA] = s[EV_RMA];
    w[P_SSE] = s[EV_SSE];
    w[P_DPE] = s[EV_DPE];
    sec_word = w;
  endfunction

  function automatic bws_evt_t sec_bits(input logic [31:0] w);
    bws_evt_t s;
    s = '0;
    s[EV_MDPE] = w[P_MDPE];
    s[EV_STA] = w[P_STA];
    s[EV_RTA] = w[P_RTA];
    s[EV_RMA] = w[P_RMA];
    s[EV_SSE] = w[P_SSE];
    s[EV_DPE] = w[P_DPE];
    sec_bits = s;
  endfunction

  function automatic logic [31:0] io_word(input bws_state_s s);
    logic [31:0] w;
    w = sec_word(s.sec);
    w[IO_BASE_IND_LSB +: 4] = IND_IO32;
    w[IO_BASE_LSB +: 4] = s.io_base;
    w[IO_LIM_IND_LSB +: 4] = IND_IO32;
    w[IO_LIM_LSB +: 4] = s.io_lim;
    io_word = w;
  endfunction

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input bws_state_s s);
    logic [31:0] w;
    w = RD_UNMAPPED;
    if (is_reg(a, OFF_BUS_LAT)) begin
      // Bus numbers live in another block; only the timer byte is ours
      w[LAT_LSB +: 8] = LAT_VAL;
    end else if (is_reg(a, OFF_IO_STS)) begin
      w = io_word(s);
    end else if (is_reg(a, OFF_MEM)) begin
      w[MEM_BASE_LSB +: 12] = s.mem_base;
      w[MEM_LIM_LSB +: 12] = s.mem_lim;
    end else if (is_reg(a, OFF_IO_UP)) begin
      w[IO_UP_BASE_LSB +: 16] = s.io_base_up;
      w[IO_UP_LIM_LSB +: 16] = s.io_lim_up;
    end else if (is_reg(a, OFF_CTRL)) begin
      w[CTRL_PERR_BIT] = s.perr_en;
      w[CTRL_SERR_BIT] = s.serr_en;
    end else if (is_reg(a, OFF_IRQ_STS)) begin
      w[EV_N-1:0] = s.irq_sts;
    end else if (is_reg(a, OFF_IRQ_MASK)) begin
      w[EV_N-1:0] = s.irq_mask;
    end
    rd_word = w;
  endfunction

  // Event qualification; the enables gate the source, so a masked event
  // is lost rather than held back for later
  always_comb begin
    evt = '0;
    evt[EV_MDPE] = par_err_i & q_ff.perr_en;
    evt[EV_STA] = cpl_abort_sent_i;
    evt[EV_RTA] = cpl_abort_rcvd_i;
    evt[EV_RMA] = cpl_ur_rcvd_i;
    evt[EV_SSE] = err_msg_sent_i & q_ff.serr_en;
    evt[EV_DPE] = poisoned_rcvd_i;
  end

  // Window bounds: low address bits are implied, not stored
  assign io_bot = {q_ff.io_base_up, q_ff.io_base, IO_LOW_ZERO};
  assign io_top = {q_ff.io_lim_up, q_ff.io_lim, IO_LOW_ONES};
  assign mem_bot = {q_ff.mem_base, MEM_LOW_ZERO};
  assign mem_top = {q_ff.mem_lim, MEM_LOW_ONES};

  always_comb begin
    logic [31:0] m;
    logic [31:0] wd;
    logic [31:0] mw;
    logic wr_ok;
    bws_evt_t sec_clr;
    bws_evt_t irq_clr;
    m = be_mask(avs_byteenable_i);
    wd = avs_writedata_i;
    mw = '0;
    sec_clr = '0;
    irq_clr = '0;
    nxt_q = q_ff;
    wr_ok = (q_ff.bst == BUS_ACK) && avs_write_i;
    nxt_q.io_fwd = (io_addr_i >= io_bot) && (io_addr_i <= io_top);
    nxt_q.mem_fwd = (mem_addr_i >= mem_bot) && (mem_addr_i <= mem_top);
    case (q_ff.bst)
      BUS_IDLE: begin
        // One wait cycle lets read data come from a flop
        if (avs_read_i || avs_write_i) begin
          nxt_q.rdata = rd_word(avs_address_i, q_ff);
          nxt_q.bst = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_q.bst = BUS_IDLE;
      end
      default: begin
        nxt_q.bst = BUS_IDLE;
      end
    endcase
    if (wr_ok) begin
      if (is_reg(avs_address_i, OFF_IO_STS)) begin
        mw = (io_word(q_ff) & ~m) | (wd & m);
        nxt_q.io_base = mw[IO_BASE_LSB +: 4];
        nxt_q.io_lim = mw[IO_LIM_LSB +: 4];
        sec_clr = sec_bits(wd & m) & SEC_W1C_MASK;
      end else if (is_reg(avs_address_i, OFF_MEM)) begin
        mw = (rd_word(avs_address_i, q_ff) & ~m) | (wd & m);
        nxt_q.mem_base = mw[MEM_BASE_LSB +: 12];
        nxt_q.mem_lim = mw[MEM_LIM_LSB +: 12];
      end else if (is_reg(avs_address_i, OFF_IO_UP)) begin
        mw = (rd_word(avs_address_i, q_ff) & ~m) | (wd & m);
        nxt_q.io_base_up = mw[IO_UP_BASE_LSB +: 16];
        nxt_q.io_lim_up = mw[IO_UP_LIM_LSB +: 16];
      end else if (is_reg(avs_address_i, OFF_CTRL)) begin
        mw = (rd_word(avs_address_i, q_ff) & ~m) | (wd & m);
        nxt_q.perr_en = mw[CTRL_PERR_BIT];
        nxt_q.serr_en = mw[CTRL_SERR_BIT];
      end else if (is_reg(avs_address_i, OFF_IRQ_STS)) begin
        irq_clr = bws_evt_t'(wd[EV_N-1:0] & m[EV_N-1:0]);
      end else if (is_reg(avs_address_i, OFF_IRQ_MASK)) begin
        mw = (rd_word(avs_address_i, q_ff) & ~m) | (wd & m);
        nxt_q.irq_mask = mw[EV_N-1:0];
      end
    end
    // A new event outweighs a clear in the same cycle
    nxt_q.sec = (q_ff.sec & ~sec_clr) | evt;
    nxt_q.irq_sts = (q_ff.irq_sts & ~irq_clr) | evt;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      q_ff <= BWS_RST;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  // Held high while frozen so no write is lost to a stopped clock enable
  assign avs_waitrequest_o = !((q_ff.bst == BUS_ACK) && ce_i);
  assign avs_readdata_o = q_ff.rdata;
  assign io_fwd_o = q_ff.io_fwd;
  assign mem_fwd_o = q_ff.mem_fwd;
  assign irq_o = |(q_ff.irq_sts & q_ff.irq_mask);

  // Checks
  logic rd_acc;
  logic wr_acc;
  assign rd_acc = avs_read_i && !avs_waitrequest_o;
  assign wr_acc = avs_write_i && !avs_waitrequest_o;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  property p_lat_zero;
    rd_acc && is_reg(avs_address_i, OFF_BUS_LAT) |-> avs_readdata_o[LAT_LSB +: 8] == LAT_VAL;
  endproperty
  a_lat_zero: assert property (p_lat_zero) else $error("latency byte not zero");

  property p_io_ind;
    rd_acc && is_reg(avs_address_i, OFF_IO_STS)
      |-> avs_readdata_o[IO_BASE_IND_LSB +: 4] == IND_IO32
       && avs_readdata_o[IO_LIM_IND_LSB +: 4] == IND_IO32
       && avs_readdata_o[23:16] == 8'h00 && avs_readdata_o[26:25] == 2'h0;
  endproperty
  a_io_ind: assert property (p_io_ind) else $error("fixed I/O or status bits wrong");

  property p_io_base_wr;
    wr_acc && ce_i && is_reg(avs_address_i, OFF_IO_STS) && avs_byteenable_i[0]
      |=> ##1 q_ff.io_base == $past(avs_writedata_i[IO_BASE_LSB +: 4], 2);
  endproperty
  a_io_base_wr: assert property (p_io_base_wr) else $error("I/O base write lost");

  property p_io_bottom;
    ce_i && io_bot <= io_top && io_addr_i == io_bot |=> io_fwd_o;
  endproperty
  a_io_bottom: assert property (p_io_bottom) else $error("I/O bottom not forwarded");

  property p_io_above;
    ce_i && io_addr_i > io_top |=> !io_fwd_o;
  endproperty
  a_io_above: assert property (p_io_above) else $error("I/O above top forwarded");

  property p_mem_below;
    ce_i && mem_addr_i < mem_bot |=> !mem_fwd_o;
  endproperty
  a_mem_below: assert property (p_mem_below) else $error("memory below base forwarded");

  property p_mdpe_gate;
    ce_i && !q_ff.perr_en && !q_ff.sec[EV_MDPE] |=> !q_ff.sec[EV_MDPE];
  endproperty
  a_mdpe_gate: assert property (p_mdpe_gate) else $error("parity flag set while disabled");

  property p_sta_set;
    ce_i && cpl_abort_sent_i |=> q_ff.sec[EV_STA] ##1 q_ff.sec[EV_STA] || !ce_i;
  endproperty
  a_sta_set: assert property (p_sta_set) else $error("abort sent flag missing");

  property p_rta_sticky;
    q_ff.sec[EV_RTA] |=> q_ff.sec[EV_RTA];
  endproperty
  a_rta_sticky: assert property (p_rta_sticky) else $error("read-only flag cleared");

  property p_sse_set;
    ce_i && err_msg_sent_i && q_ff.serr_en |=> q_ff.sec[EV_SSE];
  endproperty
  a_sse_set: assert property (p_sse_set) else $error("system error flag missing");

  property p_dpe_clr;
    wr_acc && ce_i && is_reg(avs_address_i, OFF_IO_STS) && avs_byteenable_i[3]
      && avs_writedata_i[P_DPE] && !poisoned_rcvd_i |=> !q_ff.sec[EV_DPE];
  endproperty
  a_dpe_clr: assert property (p_dpe_clr) else $error("poison flag not cleared");

  property p_dpe_set_wins;
    ce_i && poisoned_rcvd_i |=> q_ff.sec[EV_DPE] && q_ff.irq_sts[EV_DPE];
  endproperty
  a_dpe_set_wins: assert property (p_dpe_set_wins) else $error("poison event lost");

  property p_membase_lo;
    rd_acc && is_reg(avs_address_i, OFF_MEM) |-> avs_readdata_o[3:0] == 4'h0;
  endproperty
  a_membase_lo: assert property (p_membase_lo) else $error("memory reserved bits set");

  property p_io_up_rd;
    rd_acc && is_reg(avs_address_i, OFF_IO_UP)
      |-> avs_readdata_o[IO_UP_BASE_LSB +: 16] == $past(q_ff.io_base_up);
  endproperty
  a_io_up_rd: assert property (p_io_up_rd) else $error("upper I/O base readback wrong");

  property p_io_lim_wr;
    wr_acc && is_reg(avs_address_i, OFF_IO_STS) && avs_byteenable_i[1]
      |=> q_ff.io_lim == $past(avs_writedata_i[IO_LIM_LSB +: 4]);
  endproperty
  a_io_lim_wr: assert property (p_io_lim_wr) else $error("I/O limit write lost");

  property p_mem_base_wr;
    wr_acc && is_reg(avs_address_i, OFF_MEM) && avs_byteenable_i[0] && avs_byteenable_i[1]
      |=> q_ff.mem_base == $past(avs_writedata_i[MEM_BASE_LSB +: 12]);
  endproperty
  a_mem_base_wr: assert property (p_mem_base_wr) else $error("memory base write lost");

  property p_mem_lim_wr;
    wr_acc && is_reg(avs_address_i, OFF_MEM) && avs_byteenable_i[2] && avs_byteenable_i[3]
      |=> q_ff.mem_lim == $past(avs_writedata_i[MEM_LIM_LSB +: 12]);
  endproperty
  a_mem_lim_wr: assert property (p_mem_lim_wr) else $error("memory limit write lost");

  property p_io_up_wr;
    wr_acc && is_reg(avs_address_i, OFF_IO_UP) && avs_byteenable_i[0] && avs_byteenable_i[1]
      |=> q_ff.io_base_up == $past(avs_writedata_i[IO_UP_BASE_LSB +: 16]);
  endproperty
  a_io_up_wr: assert property (p_io_up_wr) else $error("upper I/O base write lost");

  property p_io_up_lim_wr;
    wr_acc && is_reg(avs_address_i, OFF_IO_UP) && avs_byteenable_i[2] && avs_byteenable_i[3]
      |=> q_ff.io_lim_up == $past(avs_writedata_i[IO_UP_LIM_LSB +: 16]);
  endproperty
  a_io_up_lim_wr: assert property (p_io_up_lim_wr) else $error("upper I/O limit write lost");

  property p_io_top;
    ce_i && io_bot <= io_top && io_addr_i == io_top |=> io_fwd_o;
  endproperty
  a_io_top: assert property (p_io_top) else $error("I/O top not forwarded");

  property p_mem_top;
    ce_i && mem_bot <= mem_top && mem_addr_i == mem_top |=> mem_fwd_o;
  endproperty
  a_mem_top: assert property (p_mem_top) else $error("memory top not forwarded");

  property p_mdpe_set;
    ce_i && par_err_i && q_ff.perr_en |=> q_ff.sec[EV_MDPE];
  endproperty
  a_mdpe_set: assert property (p_mdpe_set) else $error("parity flag missing");

  property p_rta_set;
    ce_i && cpl_abort_rcvd_i |=> q_ff.sec[EV_RTA];
  endproperty
  a_rta_set: assert property (p_rta_set) else $error("abort received flag missing");

  property p_rma_set;
    ce_i && cpl_ur_rcvd_i |=> q_ff.sec[EV_RMA];
  endproperty
  a_rma_set: assert property (p_rma_set) else $error("unsupported request flag missing");

  property p_sse_gate;
    ce_i && !q_ff.serr_en && !q_ff.sec[EV_SSE] |=> !q_ff.sec[EV_SSE];
  endproperty
  a_sse_gate: assert property (p_sse_gate) else $error("system error flag set while off");

  property p_memlim_lo;
    rd_acc && is_reg(avs_address_i, OFF_MEM) |-> avs_readdata_o[MEM_LIM_LSB-1 -: 4] == 4'h0;
  endproperty
  a_memlim_lo: assert property (p_memlim_lo) else $error("memory limit reserved bits set");

endmodule

`default_nettype wire
